/* design/tmr_chan.sv */
// one 16-bit timer instance: count, prescaler, sixteen-bit access buffer and events
`timescale 1ns/1ps
module tmr_chan
    import tmr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // timing and configuration
    input  wire logic        tick_i,
    input  wire logic [7:0]  ctrl_i,
    input  wire logic        gate_en_i,
    input  wire logic        gate_level_i,
    input  wire tmr_cmp_type cmp_i,
    // register access
    input  wire logic        wr_lo_i,
    input  wire logic        wr_hi_i,
    input  wire logic        rd_lo_i,
    input  wire logic [7:0]  wdata_i,
    // state and events
    output logic [7:0]       cnt_lo_o,
    output logic [7:0]       cnt_hi_o,
    output tmr_evt_type      evt_o
);
    logic [15:0] count_r;
    logic [7:0]  hi_buf_r;
    logic [2:0]  pre_r;
    logic        gate_d_r;
    logic [2:0]  pre_max;
    logic        sixteen_bit_access;
    logic        cnt_en;
    logic        step;
    logic        sevt;
    logic        load;
    logic [15:0] load_val;

    assign sixteen_bit_access    = ctrl_i[CTRL_SIXTEEN_BIT_ACCESS];
    assign pre_max = 3'((4'h1 << ctrl_i[CTRL_CKPS +: 2]) - 4'h1);
    assign cnt_en  = tick_i & ctrl_i[CTRL_ON] & (~gate_en_i | gate_level_i);
    assign step    = cnt_en & (pre_r == pre_max);
    // compare value acts as period: match on the step that would leave it
    assign sevt    = (cmp_i.mode == MODE_SEVT) & (count_r == cmp_i.value) & step; // RULE_08 RULE_11
    assign load    = wr_lo_i | (wr_hi_i & ~sixteen_bit_access);
    assign load_val = wr_lo_i ? {(sixteen_bit_access ? hi_buf_r : count_r[15:8]), wdata_i} // RULE_15
                              : {wdata_i, count_r[7:0]};

    // prescaler, cleared by a low byte write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_r <= 3'h0;
        end else if (wr_lo_i) begin
            pre_r <= 3'h0;
        end else if (cnt_en) begin
            pre_r <= (pre_r == pre_max) ? 3'h0 : pre_r + 3'h1;
        end
    end

    // count: write beats trigger, trigger beats increment
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_r <= CNT_ZERO;
        end else if (load) begin
            count_r <= load_val; // RULE_12
        end else if (sevt) begin
            count_r <= CNT_ZERO; // RULE_08
        end else if (step) begin
            count_r <= count_r + 16'h0001; // RULE_04
        end
    end

    // high byte buffer for sixteen-bit access
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hi_buf_r <= 8'h00;
        end else if (rd_lo_i & sixteen_bit_access) begin
            hi_buf_r <= count_r[15:8]; // RULE_15
        end else if (wr_hi_i & sixteen_bit_access) begin
            hi_buf_r <= wdata_i; // RULE_15
        end
    end

    // gate level history, independent of gate count enable
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gate_d_r <= 1'h0;
        end else begin
            gate_d_r <= gate_level_i; // RULE_03
        end
    end

    assign cnt_lo_o       = count_r[7:0];
    assign cnt_hi_o       = sixteen_bit_access ? hi_buf_r : count_r[15:8];
    // trigger reset never raises the overflow event
    assign evt_o.ovf      = step & (count_r == CNT_MAX) & ~load & ~sevt; // RULE_05 RULE_13
    assign evt_o.gate_evt = gate_d_r & ~gate_level_i; // RULE_01 RULE_03
    assign evt_o.sevt     = sevt & ~load;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    write_wins_a: assert property (wr_lo_i |=> count_r[7:0] == $past(wdata_i)) // RULE_12
        else $error("low byte write lost");
    wrap_zero_a: assert property (evt_o.ovf |=> count_r == CNT_ZERO) // RULE_04
        else $error("count did not wrap to zero");
    trig_clear_a: assert property ((sevt && !load) |-> !evt_o.ovf ##1 count_r == CNT_ZERO) // RULE_08 RULE_13
        else $error("trigger did not clear count");
    gate_fall_a: assert property ($fell(gate_level_i) |-> evt_o.gate_evt) // RULE_01
        else $error("gate falling edge missed");
    buf_load_a: assert property ((wr_lo_i && sixteen_bit_access) |=> count_r[15:8] == $past(hi_buf_r)) // RULE_15
        else $error("high byte not loaded from buffer");
endmodule : tmr_chan

/* design/tmr_pkg.sv */
// package: register map, field positions, timing counts and carrier types of the timer block
package tmr_pkg;
    // number of timer instances
    localparam int NUM_TMR = 3;
    // per-timer register window
    localparam logic [7:0] TMR_STRIDE = 8'h10;
    localparam logic [7:0] OFS_CNT_LO = 8'h00;
    localparam logic [7:0] OFS_CNT_HI = 8'h04;
    localparam logic [7:0] OFS_CTRL   = 8'h08;
    localparam logic [7:0] OFS_GCTRL  = 8'h0c;
    // flag and enable registers: index 0 = register 2, 1 = register 3, 2 = register 5
    localparam int NUM_IREG = 3;
    localparam logic [7:0] FLAG_ADR [NUM_IREG] = '{8'h30, 8'h34, 8'h38};
    localparam logic [7:0] EN_ADR   [NUM_IREG] = '{8'h3c, 8'h40, 8'h44};
    localparam logic [7:0] IREG_MASK [NUM_IREG] = '{8'h03, 8'h80, 8'h8a};
    // placement of each timer's flags
    localparam int OVF_REG [NUM_TMR] = '{0, 2, 2};
    localparam int OVF_BIT [NUM_TMR] = '{1, 1, 3};
    localparam int GEV_REG [NUM_TMR] = '{0, 1, 2};
    localparam int GEV_BIT [NUM_TMR] = '{0, 7, 7};
    // control register fields
    localparam int CTRL_ON   = 0;
    localparam int CTRL_SIXTEEN_BIT_ACCESS = 1;
    localparam int CTRL_SYNC = 2;
    localparam int CTRL_CKPS = 4;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    // gate control register fields
    localparam int GCTRL_GVAL = 2;
    localparam int GCTRL_GE   = 7;
    localparam logic [7:0] GCTRL_RST = 8'h00;
    // counter values
    localparam logic [15:0] CNT_MAX  = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    // compare mode that raises the special event trigger
    localparam logic [3:0] MODE_SEVT = 4'hb;
    // system clocks per instruction cycle
    localparam int INSTR_DIV = 4;
    // compare module facing one timer
    typedef struct packed {
        logic [3:0]  mode;
        logic [15:0] value;
        logic        second;
    } tmr_cmp_type;
    // one-cycle events of one timer
    typedef struct packed {
        logic ovf;
        logic gate_evt;
        logic sevt;
    } tmr_evt_type;
endpackage : tmr_pkg

/* design/tmr_top.sv */
// three 16-bit timers with gate event and overflow flags behind a classic Wishbone slave
// How it works
// RULE_01: a high-to-low change of a timer's gate level sets that timer's gate event flag.
// RULE_02: a gate event flag asks for an interrupt only while its enable bit is also set.
// RULE_03: gate event flags keep working while gate count enable is off.
// RULE_04: each 16-bit count climbs from zero to all ones and then wraps to zero.
// RULE_05: every wrap latches the overflow flag, which interrupts only when its enable is set.
// RULE_06: overflow flags sit at bit 1 of flag register 2 and bits 1 and 3 of flag register 5.
// RULE_07: overflow enables sit at bit 1 of enable register 2 and bits 1 and 3 of enable register 5.
// RULE_08: a special event trigger from a compare module in mode 1011 clears the count.
// RULE_09: a trigger from the second compare module also starts a conversion when the converter is on.
// RULE_10: software uses timer or synchronous counter mode when it relies on the trigger reset.
// RULE_11: with the trigger reset in use the compare value is the period of the count.
// RULE_12: a count write in the same cycle as a trigger keeps the written value.
// RULE_13: a trigger reset clears the count and never sets the overflow flag.
// RULE_14: the gate level status bit always shows the live gate level.
// RULE_15: with sixteen-bit access, a low byte read fills the high buffer and a low write loads it.
// RULE_16: flags stay set until software clears them, and a new event beats a clear.
// RULE_17: each timer drives its own flags and trigger input and shares only the flag registers; the code also shares the enable registers.
`timescale 1ns/1ps
module tmr_top
    import tmr_pkg::*;
#(
    parameter int N = NUM_TMR
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    // gate logic side
    input  wire logic [N-1:0]          gate_level_i,
    output logic [N-1:0][7:0]          gate_ctrl_o,
    // compare modules and converter
    input  wire tmr_cmp_type [N-1:0]   cmp_i,
    input  wire logic                  adc_en_i,
    output logic                       adc_start_o,
    // interrupt
    output logic                       irq_o
);
    logic                  ack_r;
    logic [31:0]           dat_r;
    logic [1:0]            div_r;
    logic                  tick;
    logic                  acc;
    logic                  wr;
    logic                  rd;
    logic [N-1:0]          wr_lo;
    logic [N-1:0]          wr_hi;
    logic [N-1:0]          rd_lo;
    logic [N-1:0][7:0]     ctrl_r;
    logic [N-1:0][7:0]     gctrl_r;
    logic [N-1:0][7:0]     cnt_lo;
    logic [N-1:0][7:0]     cnt_hi;
    tmr_evt_type [N-1:0]   evt;
    logic [NUM_IREG-1:0][7:0] flag_r;
    logic [NUM_IREG-1:0][7:0] en_r;
    logic [NUM_IREG-1:0][7:0] flag_set;
    logic [NUM_IREG-1:0][7:0] flag_clr;
    logic [7:0]            rd_mux;
    logic                  adc_start_r;
    logic                  sevt_second;

    // bus strobes: one access per request, taken the cycle before ack
    assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr  = acc & wb_we_i & wb_sel_i[0];
    assign rd  = acc & ~wb_we_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'h0;
        end else begin
            ack_r <= acc;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (acc) begin
            dat_r <= {24'h00_0000, rd_mux};
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // instruction cycle enable
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= 2'h0;
        end else begin
            div_r <= (div_r == 2'(INSTR_DIV - 1)) ? 2'h0 : div_r + 2'h1;
        end
    end

    assign tick = (div_r == 2'(INSTR_DIV - 1));

    // timer instances, each with its own state
    for (genvar i = 0; i < N; i++) begin : g_tmr
        localparam logic [7:0] BASE = 8'(i * TMR_STRIDE);

        assign wr_lo[i] = wr & (wb_adr_i == BASE + OFS_CNT_LO);
        assign wr_hi[i] = wr & (wb_adr_i == BASE + OFS_CNT_HI);
        assign rd_lo[i] = rd & (wb_adr_i == BASE + OFS_CNT_LO);

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                ctrl_r[i] <= CTRL_RST;
            end else if (wr & (wb_adr_i == BASE + OFS_CTRL)) begin
                ctrl_r[i] <= wb_dat_i[7:0];
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                gctrl_r[i] <= GCTRL_RST;
            end else if (wr & (wb_adr_i == BASE + OFS_GCTRL)) begin
                gctrl_r[i] <= wb_dat_i[7:0];
            end
        end

        assign gate_ctrl_o[i] = gctrl_r[i];

        tmr_chan u_chan (
            .clk_i        (clk_i),
            .rst_i        (rst_i),
            .tick_i       (tick),
            .ctrl_i       (ctrl_r[i]),
            .gate_en_i    (gctrl_r[i][GCTRL_GE]),
            .gate_level_i (gate_level_i[i]),
            .cmp_i        (cmp_i[i]), // RULE_17
            .wr_lo_i      (wr_lo[i]),
            .wr_hi_i      (wr_hi[i]),
            .rd_lo_i      (rd_lo[i]),
            .wdata_i      (wb_dat_i[7:0]),
            .cnt_lo_o     (cnt_lo[i]),
            .cnt_hi_o     (cnt_hi[i]),
            .evt_o        (evt[i])
        );
    end

    // read data
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < N; i++) begin
            if (wb_adr_i == 8'(i * TMR_STRIDE) + OFS_CNT_LO) begin
                rd_mux = cnt_lo[i];
            end
            if (wb_adr_i == 8'(i * TMR_STRIDE) + OFS_CNT_HI) begin
                rd_mux = cnt_hi[i];
            end
            if (wb_adr_i == 8'(i * TMR_STRIDE) + OFS_CTRL) begin
                rd_mux = ctrl_r[i];
            end
            if (wb_adr_i == 8'(i * TMR_STRIDE) + OFS_GCTRL) begin
                rd_mux = gctrl_r[i];
                rd_mux[GCTRL_GVAL] = gate_level_i[i]; // RULE_14
            end
        end
        for (int k = 0; k < NUM_IREG; k++) begin
            if (wb_adr_i == FLAG_ADR[k]) begin
                rd_mux = flag_r[k];
            end
            if (wb_adr_i == EN_ADR[k]) begin
                rd_mux = en_r[k];
            end
        end
    end

    // route each timer's events to its own flag bits
    always_comb begin
        flag_set = '0;
        for (int i = 0; i < N; i++) begin
            flag_set[OVF_REG[i]][OVF_BIT[i]] = evt[i].ovf; // RULE_05 RULE_06
            flag_set[GEV_REG[i]][GEV_BIT[i]] = evt[i].gate_evt; // RULE_01
        end
    end

    // flags: sticky, cleared by writing one, set wins over clear
    for (genvar k = 0; k < NUM_IREG; k++) begin : g_ireg
        assign flag_clr[k] = (wr & (wb_adr_i == FLAG_ADR[k])) ? wb_dat_i[7:0] : 8'h00;

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                flag_r[k] <= 8'h00;
            end else begin
                flag_r[k] <= ((flag_r[k] & ~flag_clr[k]) | flag_set[k]) & IREG_MASK[k]; // RULE_16
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                en_r[k] <= 8'h00;
            end else if (wr & (wb_adr_i == EN_ADR[k])) begin
                en_r[k] <= wb_dat_i[7:0] & IREG_MASK[k]; // RULE_07
            end
        end
    end

    assign irq_o = |(flag_r & en_r); // RULE_02 RULE_05

    // conversion start from the second compare module
    always_comb begin
        sevt_second = 1'h0;
        for (int i = 0; i < N; i++) begin
            sevt_second = sevt_second | (evt[i].sevt & cmp_i[i].second);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            adc_start_r <= 1'h0;
        end else begin
            adc_start_r <= sevt_second & adc_en_i; // RULE_09
        end
    end

    assign adc_start_o = adc_start_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence req_s;
        wb_cyc_i && wb_stb_i && !ack_r;
    endsequence

    sequence answer_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_answer_a: assert property (req_s |=> answer_s)
        else $error("bus answer not one cycle after request");
    irq_level_a: assert property (irq_o == ((flag_r[0] & en_r[0]) != 8'h00 // RULE_02
                                  || (flag_r[1] & en_r[1]) != 8'h00
                                  || (flag_r[2] & en_r[2]) != 8'h00))
        else $error("interrupt level disagrees with flags");
    ovf_flag_a: assert property (evt[0].ovf |=> flag_r[0][1]) // RULE_06
        else $error("first timer overflow flag not set");
    gate_flag_a: assert property (evt[2].gate_evt |=> flag_r[2][7]) // RULE_01
        else $error("third timer gate flag not set");
    flag_hold_a: assert property ((flag_r[2][3] && !(wr && wb_adr_i == FLAG_ADR[2] && wb_dat_i[3])) // RULE_16
                                  |=> flag_r[2][3])
        else $error("flag dropped without clear");
    adc_start_a: assert property ((sevt_second && adc_en_i) |=> adc_start_o) // RULE_09
        else $error("conversion start missing");
    adc_gate_a: assert property (adc_start_o |-> $past(adc_en_i)) // RULE_09
        else $error("conversion started while converter off");
    gval_read_a: assert property ((rd && wb_adr_i == OFS_GCTRL) // RULE_14
                                  |=> wb_dat_o[GCTRL_GVAL] == $past(gate_level_i[0]))
        else $error("gate level status not live");
endmodule : tmr_top

/* tb/testbench.sv */
// self-checking bench for the three-timer block
`timescale 1ns/1ps
module testbench
    import tmr_pkg::*;
;
    typedef struct packed {
        logic       we;
        logic       sel;
        logic [7:0] adr;
        logic [7:0] wd;
        logic [7:0] exp;
    } tmr_row_type;

    localparam tmr_row_type ROWS [21] = '{
        '{1'h0, 1'h1, 8'h08, 8'h00, 8'h00}, '{1'h0, 1'h1, 8'h0c, 8'h00, 8'h00}, '{1'h0, 1'h1, 8'h38, 8'h00, 8'h00},
        '{1'h1, 1'h1, 8'h3c, 8'hff, 8'h00}, '{1'h0, 1'h1, 8'h3c, 8'h00, 8'h03}, '{1'h1, 1'h1, 8'h40, 8'hff, 8'h00},
        '{1'h0, 1'h1, 8'h40, 8'h00, 8'h80}, '{1'h1, 1'h1, 8'h44, 8'hff, 8'h00}, '{1'h0, 1'h1, 8'h44, 8'h00, 8'h8a},
        '{1'h1, 1'h1, 8'h3c, 8'h00, 8'h00}, '{1'h1, 1'h1, 8'h40, 8'h00, 8'h00}, '{1'h1, 1'h1, 8'h44, 8'h00, 8'h00},
        '{1'h1, 1'h1, 8'h50, 8'hff, 8'h00}, '{1'h0, 1'h1, 8'h50, 8'h00, 8'h00}, '{1'h1, 1'h0, 8'h08, 8'h30, 8'h00},
        '{1'h0, 1'h1, 8'h08, 8'h00, 8'h00}, '{1'h1, 1'h1, 8'h1c, 8'h7f, 8'h00}, '{1'h0, 1'h1, 8'h1c, 8'h00, 8'h7b},
        '{1'h1, 1'h1, 8'h1c, 8'h00, 8'h00}, '{1'h1, 1'h1, 8'h30, 8'hff, 8'h00}, '{1'h0, 1'h1, 8'h30, 8'h00, 8'h00}
    };

    logic                       clk_i;
    logic                       rst_i;
    logic                       wb_cyc;
    logic                       wb_stb;
    logic                       wb_we;
    logic [7:0]                 wb_adr;
    logic [3:0]                 wb_sel;
    logic [31:0]                wb_dat;
    logic [31:0]                wb_rdat;
    logic                       wb_ack;
    logic [NUM_TMR-1:0]         gate_level;
    logic [NUM_TMR-1:0][7:0]    gate_ctrl;
    tmr_cmp_type [NUM_TMR-1:0]  cmp;
    logic                       adc_en;
    logic                       adc_start;
    logic                       irq;
    int                         n_fail = 0;
    int                         n_checks = 0;
    int                         n_adc = 0;

    tmr_top #(.N(NUM_TMR)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .gate_level_i(gate_level), .gate_ctrl_o(gate_ctrl), .cmp_i(cmp), .adc_en_i(adc_en),
        .adc_start_o(adc_start), .irq_o(irq)
    );

    tmr_far_model i_far (.clk_i(clk_i), .gate_level_o(gate_level), .cmp_o(cmp), .adc_en_o(adc_en));

    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (adc_start === 1'h1) begin
            n_adc <= n_adc + 1;
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic give_up(input string what);
        n_fail++;
        $display("BAD %s expected done seen timeout", what);
        close_out();
    endtask : give_up

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask : chk

    task automatic wb(input logic we, input logic sel, input logic [7:0] adr, input logic [7:0] d,
                      output logic [31:0] q);
        int k;
        @(posedge clk_i);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we  <= we;
        wb_sel <= {3'h0, sel};
        wb_adr <= adr;
        wb_dat <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack !== 1'h1 && k < 16);
        if (k >= 16) begin
            give_up("bus ack");
        end
        q = wb_rdat;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we  <= 1'h0;
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] q;
        wb(1'h1, 1'h1, adr, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] adr, output logic [31:0] q);
        wb(1'h0, 1'h1, adr, 8'h00, q);
    endtask : rd

    initial begin
        logic [31:0] q;
        logic [7:0]  base;
        logic [7:0]  bv;
        int          k;
        rst_i  = 1'h1;
        wb_cyc = 1'h0;
        wb_stb = 1'h0;
        wb_we  = 1'h0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat = 32'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        foreach (ROWS[r]) begin
            wb(ROWS[r].we, ROWS[r].sel, ROWS[r].adr, ROWS[r].wd, q);
            if (!ROWS[r].we) begin
                chk("register row", {24'h0, ROWS[r].exp}, q);
            end
        end
        $display("test register rows done");
        for (int i = 0; i < NUM_TMR; i++) begin
            base = 8'(i) * TMR_STRIDE;
            bv = 8'h01 << OVF_BIT[i];
            wr(base + OFS_CNT_HI, 8'hff);
            wr(base + OFS_CNT_LO, 8'hfe);
            wr(base + OFS_CTRL, 8'h05);
            k = 0;
            do begin
                rd(FLAG_ADR[OVF_REG[i]], q);
                k++;
            end while (q === 32'h0 && k < 20);
            if (q === 32'h0) begin
                give_up("overflow flag");
            end
            chk("overflow flag", {24'h0, bv}, q);
            chk("irq masked", 32'h0, {31'h0, irq});
            wr(base + OFS_CTRL, 8'h00);
            rd(base + OFS_CNT_HI, q);
            chk("count wrapped", 32'h0, q);
            wr(EN_ADR[OVF_REG[i]], bv);
            chk("irq enabled", 32'h1, {31'h0, irq});
            wr(FLAG_ADR[OVF_REG[i]], bv);
            chk("irq after clear", 32'h0, {31'h0, irq});
            wr(EN_ADR[OVF_REG[i]], 8'h00);
            bv = 8'h01 << GEV_BIT[i];
            i_far.set_gate(i, 1'h1);
            rd(base + OFS_GCTRL, q);
            chk("gate level status", 32'h4, q);
            i_far.set_gate(i, 1'h0);
            rd(FLAG_ADR[GEV_REG[i]], q);
            chk("gate event flag", {24'h0, bv}, q);
            wr(EN_ADR[GEV_REG[i]], bv);
            chk("gate irq", 32'h1, {31'h0, irq});
            wr(FLAG_ADR[GEV_REG[i]], bv);
            chk("gate irq cleared", 32'h0, {31'h0, irq});
            wr(EN_ADR[GEV_REG[i]], 8'h00);
        end
        $display("test overflow and gate events done");
        base = TMR_STRIDE;
        i_far.set_adc(1'h1);
        i_far.set_cmp(1, MODE_SEVT, CNT_MAX);
        wr(base + OFS_CNT_HI, 8'hff);
        wr(base + OFS_CNT_LO, 8'hf0);
        wr(base + OFS_CTRL, 8'h05);
        k = 0;
        while (n_adc == 0 && k < 200) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 200) begin
            give_up("conversion start");
        end
        wr(base + OFS_CTRL, 8'h00);
        rd(FLAG_ADR[OVF_REG[1]], q);
        chk("no overflow on trigger", 32'h0, q);
        rd(base + OFS_CNT_HI, q);
        chk("trigger cleared count", 32'h0, q);
        chk("conversion starts", 32'h1, 32'(n_adc));
        i_far.set_adc(1'h0);
        i_far.set_cmp(1, MODE_SEVT, 16'h0003);
        wr(base + OFS_CNT_HI, 8'h00);
        wr(base + OFS_CNT_LO, 8'h00);
        wr(base + OFS_CTRL, 8'h05);
        repeat (8) begin
            rd(base + OFS_CNT_LO, q);
            chk("count within period", 32'h1, {31'h0, q <= 32'h3});
        end
        i_far.set_cmp(1, MODE_SEVT, 16'h0055);
        repeat (4) begin
            wr(base + OFS_CNT_LO, 8'h55);
        end
        wr(base + OFS_CTRL, 8'h00);
        chk("no start with converter off", 32'h1, 32'(n_adc));
        i_far.set_cmp(1, 4'h0, 16'h0000);
        $display("test trigger reset done");
        base = 8'h02 * TMR_STRIDE;
        wr(base + OFS_CTRL, 8'h02);
        wr(base + OFS_CNT_HI, 8'h12);
        wr(base + OFS_CNT_LO, 8'h34);
        wr(base + OFS_CNT_HI, 8'h56);
        rd(base + OFS_CNT_LO, q);
        chk("buffered low", 32'h34, q);
        rd(base + OFS_CNT_HI, q);
        chk("buffered high", 32'h12, q);
        wr(base + OFS_CTRL, 8'h00);
        rd(base + OFS_CNT_HI, q);
        chk("live high", 32'h12, q);
        $display("test sixteen-bit access done");
        wr(OFS_GCTRL, 8'ha0);
        chk("gate control out", 32'ha0, 32'(gate_ctrl[0]));
        wr(EN_ADR[0], 8'h03);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        chk("gate control reset", 32'h0, 32'(gate_ctrl));
        rd(EN_ADR[0], q);
        chk("enable reset", 32'h0, q);
        $display("test mid-run reset done");
        close_out();
    end
endmodule : testbench

/* tb/tmr_far_model.sv */
// far-side model: compare modules, gate sources and converter enable facing the timers
`timescale 1ns/1ps
module tmr_far_model
    import tmr_pkg::*;
(
    // clock
    input  wire logic                 clk_i,
    // toward the timers
    output logic        [NUM_TMR-1:0] gate_level_o,
    output tmr_cmp_type [NUM_TMR-1:0] cmp_o,
    output logic                      adc_en_o
);
    initial begin
        gate_level_o    = '0;
        adc_en_o        = 1'h0;
        cmp_o           = '0;
        cmp_o[1].second = 1'h1;
    end

    // gate level source; a falling level marks a finished gate event
    task automatic set_gate(input int i, input logic v);
        @(posedge clk_i);
        gate_level_o[i] <= v;
    endtask : set_gate

    task automatic set_cmp(input int i, input logic [3:0] m, input logic [15:0] v);
        @(posedge clk_i);
        cmp_o[i].mode  <= m;
        cmp_o[i].value <= v;
    endtask : set_cmp

    task automatic set_adc(input logic v);
        @(posedge clk_i);
        adc_en_o <= v;
    endtask : set_adc
endmodule : tmr_far_model
